// ### logic/pap_defs.vh
// constants for the pcm / i2s audio port: offsets, fields, timing
// assumes a 25 MHz system clock and a 32-bit wishbone register bus
`ifndef PAP_DEFS_VH
`define PAP_DEFS_VH

////////////////////////////////////////////////////////////////////////
// system clock and pcm bit rates
`define PAP_CLK_HZ      25000000
`define PAP_WBS_BIT_HZ  64000
`define PAP_SBC_BIT_HZ  256000
`define PAP_WBS_HALF    (`PAP_CLK_HZ / (2 * `PAP_WBS_BIT_HZ))
`define PAP_SBC_HALF    (`PAP_CLK_HZ / (2 * `PAP_SBC_BIT_HZ))
`define PAP_PCM_DIV_RST 16'h00C3
`define PAP_LSYNC_BITS  7'h03

////////////////////////////////////////////////////////////////////////
// register byte offsets
`define PAP_REG_CTRL    8'h00
`define PAP_REG_PDIV    8'h04
`define PAP_REG_PTX     8'h08
`define PAP_REG_PRX     8'h0C
`define PAP_REG_STAT    8'h10
`define PAP_REG_I0TX    8'h14
`define PAP_REG_I0RX    8'h18
`define PAP_REG_I1TX    8'h1C
`define PAP_REG_I1RX    8'h20

////////////////////////////////////////////////////////////////////////
// control fields
`define PAP_PCM_EN      0
`define PAP_PCM_MST     1
`define PAP_PCM_MODE    2
`define PAP_PCM_LONG    4
`define PAP_PCM_LOG     5
`define PAP_PCM_SLOT    7
`define PAP_I0_EN       16
`define PAP_I1_EN       20
`define PAP_LOCK_PCM    32'h000001FE
`define PAP_LOCK_I0     32'h00060000
`define PAP_LOCK_I1     32'h00600000
`define PAP_CTRL_RST    32'h00000000

// pcm modes
`define PAP_MODE_WBS    2'h0
`define PAP_MODE_SBC    2'h1
`define PAP_MODE_MUX    2'h2
`define PAP_MODE_BURST  2'h3

// status bits
`define PAP_ST_RXNEW    0
`define PAP_ST_SLIP     1
`define PAP_ST_REFUSE   2
`define PAP_ST_I0PAIR   3
`define PAP_ST_I1PAIR   4
`define PAP_ST_MUXBAD   5
`define PAP_ST_W1C      6'h26

////////////////////////////////////////////////////////////////////////
// i2s master n/m divider, edge rate = 2 x bit clock
`define PAP_I2S_N32     16'h0180
`define PAP_I2S_M32     16'h0C35
`define PAP_I2S_N50     16'h0018
`define PAP_I2S_M50     16'h007D
`define PAP_I2S_F32     6'h20
`define PAP_I2S_F50     6'h32
`define PAP_I2S_H32     6'h10
`define PAP_I2S_H50     6'h19

`endif

// ### logic/pap_i2s.v
// one i2s port: master or slave, 16-bit words, left while ws low
// assumes pin inputs are asynchronous; slave bit clock at most 3.072 MHz
`include "pap_defs.vh"

module pap_i2s (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire        en_in,
    input  wire        master_in,
    input  wire        wide_in,
    input  wire [15:0] tx_left_in,
    input  wire [15:0] tx_right_in,
    input  wire        sck_in,
    input  wire        ws_in,
    input  wire        sdi_in,
    output reg         sck_out,
    output reg         sck_oe_out,
    output reg         ws_out,
    output reg         ws_oe_out,
    output reg         sdo_out,
    output reg         sdo_oe_out,
    output reg  [15:0] rx_left_out,
    output reg  [15:0] rx_right_out,
    output reg         pair_out
);

    reg  [2:0]  s1_reg;
    reg  [2:0]  s2_reg;
    reg         sck_s3_reg;
    reg  [15:0] acc_reg;
    reg  [5:0]  cnt_reg;
    reg  [4:0]  pos_reg;
    reg         chan_reg;
    reg         wsl_reg;
    reg  [15:0] sh_reg;
    reg  [31:0] txw_reg;

    wire [15:0] div_n  = wide_in ? `PAP_I2S_N50 : `PAP_I2S_N32;
    wire [15:0] div_m  = wide_in ? `PAP_I2S_M50 : `PAP_I2S_M32;
    wire [16:0] sum    = {1'b0, acc_reg} + {1'b0, div_n};
    wire        tick   = en_in & master_in & (sum >= {1'b0, div_m});
    wire [5:0]  flen   = wide_in ? `PAP_I2S_F50 : `PAP_I2S_F32;
    wire [5:0]  half   = wide_in ? `PAP_I2S_H50 : `PAP_I2S_H32;
    wire [5:0]  cnt_n  = (cnt_reg == flen - 6'h01) ? 6'h00
                                                   : cnt_reg + 6'h01;
    wire        rise   = en_in & (master_in ? tick & ~sck_out
                                            : s2_reg[0] & ~sck_s3_reg);
    wire        fall   = en_in & (master_in ? tick & sck_out
                                            : ~s2_reg[0] & sck_s3_reg);
    wire        ws_cur = master_in ? ws_out : s2_reg[1];
    wire        in_wd  = ~pos_reg[4];
    wire [15:0] cur    = in_wd ? {sh_reg[14:0], s2_reg[2]} : sh_reg;
    wire [15:0] txsel  = chan_reg ? txw_reg[31:16] : txw_reg[15:0];

    always @(posedge clk_in) begin
        if (!rst_n_in || !en_in) begin
            s1_reg       <= 3'h0;
            s2_reg       <= 3'h0;
            sck_s3_reg   <= 1'b0;
            acc_reg      <= 16'h0000;
            cnt_reg      <= 6'h00;
            pos_reg      <= 5'h1F;
            chan_reg     <= 1'b0;
            wsl_reg      <= 1'b0;
            sh_reg       <= 16'h0000;
            txw_reg      <= 32'h00000000;
            sck_out      <= 1'b0;
            sck_oe_out   <= 1'b0;
            ws_out       <= 1'b0;
            ws_oe_out    <= 1'b0;
            sdo_out      <= 1'b0;
            sdo_oe_out   <= 1'b0;
            pair_out     <= 1'b0;
            if (!rst_n_in) begin
                rx_left_out  <= 16'h0000;
                rx_right_out <= 16'h0000;
            end
        end else begin
            s1_reg     <= {sdi_in, ws_in, sck_in};
            s2_reg     <= s1_reg;
            sck_s3_reg <= s2_reg[0];
            sck_oe_out <= master_in;
            ws_oe_out  <= master_in;
            sdo_oe_out <= 1'b1;
            pair_out   <= 1'b0;
            // fractional n/m accumulator for the master bit clock
            acc_reg <= tick ? sum[15:0] - div_m : sum[15:0];
            if (tick)
                sck_out <= ~sck_out;
            if (fall) begin
                if (master_in) begin
                    cnt_reg <= cnt_n;
                    ws_out  <= (cnt_n >= half);
                end
                // msb one bit after ws edge, zero past the word
                sdo_out <= in_wd & txsel[~pos_reg[3:0]];
            end
            if (rise) begin
                wsl_reg <= ws_cur;
                sh_reg  <= cur;
                if (ws_cur != wsl_reg) begin
                    if (chan_reg)
                        rx_right_out <= cur;
                    else
                        rx_left_out <= cur;
                    pair_out <= chan_reg;
                    chan_reg <= ws_cur;
                    pos_reg  <= 5'h00;
                    if (!ws_cur)
                        txw_reg <= {tx_right_in, tx_left_in};
                end else if (pos_reg != 5'h1F) begin
                    pos_reg <= pos_reg + 5'h01;
                end
            end
        end
    end

endmodule

// ### logic/pap_top.v
// pcm port plus two i2s ports behind a classic wishbone slave
// assumes audio pins are asynchronous; software configures and starts
`include "pap_defs.vh"

////////////////////////////////////////////////////////////////////////
module pap_top (
    input  wire        CLK_IN,
    input  wire        RST_N_IN,
    input  wire        WB_CYC_IN,
    input  wire        WB_STB_IN,
    input  wire        WB_WE_IN,
    input  wire [7:0]  WB_ADR_IN,
    input  wire [3:0]  WB_SEL_IN,
    input  wire [31:0] WB_DAT_IN,
    output reg  [31:0] WB_DAT_OUT,
    output reg         WB_ACK_OUT,
    input  wire        PCM_CLK_IN,
    output reg         PCM_CLK_OUT,
    output reg         PCM_CLK_OE_OUT,
    input  wire        PCM_SYNC_IN,
    output reg         PCM_SYNC_OUT,
    output reg         PCM_SYNC_OE_OUT,
    input  wire        PCM_DIN_IN,
    output reg         PCM_DOUT_OUT,
    output reg         PCM_DOUT_OE_OUT,
    input  wire        I2S0_SCK_IN,
    output wire        I2S0_SCK_OUT,
    output wire        I2S0_SCK_OE_OUT,
    input  wire        I2S0_WS_IN,
    output wire        I2S0_WS_OUT,
    output wire        I2S0_WS_OE_OUT,
    input  wire        I2S0_SDI_IN,
    output wire        I2S0_SDO_OUT,
    output wire        I2S0_SDO_OE_OUT,
    input  wire        I2S1_SCK_IN,
    output wire        I2S1_SCK_OUT,
    output wire        I2S1_SCK_OE_OUT,
    input  wire        I2S1_WS_IN,
    output wire        I2S1_WS_OUT,
    output wire        I2S1_WS_OE_OUT,
    input  wire        I2S1_SDI_IN,
    output wire        I2S1_SDO_OUT,
    output wire        I2S1_SDO_OE_OUT
);

    // byte-lane merge of a write into an old register value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (sel[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    reg  [31:0] ctrl_reg;
    reg  [15:0] pdiv_reg;
    reg  [15:0] ptx_reg;
    reg         fresh_reg;
    reg  [15:0] prx_reg;
    reg  [5:0]  stat_reg;
    reg  [31:0] i0tx_reg;
    reg  [31:0] i1tx_reg;
    reg  [31:0] rdat;

    wire [15:0] i0_rxl;
    wire [15:0] i0_rxr;
    wire        i0_pair;
    wire [15:0] i1_rxl;
    wire [15:0] i1_rxr;
    wire        i1_pair;

    ////////////////////////////////////////////////////////////////////
    // pcm configuration decode
    wire [1:0]  mode  = ctrl_reg[`PAP_PCM_MODE +: 2];
    wire        burst = (mode == `PAP_MODE_BURST);
    wire        mux   = (mode == `PAP_MODE_MUX);
    wire        lng   = ctrl_reg[`PAP_PCM_LONG];
    wire        mst   = ctrl_reg[`PAP_PCM_MST] & ~burst;
    wire        muxbad = mux & ~ctrl_reg[`PAP_PCM_MST];
    wire        run   = ctrl_reg[`PAP_PCM_EN] & ~muxbad;
    wire [1:0]  lg    = mux ? ctrl_reg[`PAP_PCM_LOG +: 2] : 2'h0;
    wire [1:0]  slot  = mux ? ctrl_reg[`PAP_PCM_SLOT +: 2] : 2'h0;
    wire [7:0]  flen  = 8'h10 << lg;
    wire [31:0] wbs_h = `PAP_WBS_HALF;
    wire [31:0] sbc_h = `PAP_SBC_HALF;
    reg  [15:0] half;

    always @* begin
        case (mode)
            `PAP_MODE_WBS: half = wbs_h[15:0];
            `PAP_MODE_SBC: half = sbc_h[15:0];
            `PAP_MODE_MUX: half = pdiv_reg >> lg;
            default:       half = pdiv_reg;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // pcm bit engine
    reg  [2:0]  s1_reg;
    reg  [2:0]  s2_reg;
    reg         clk_s3_reg;
    reg  [15:0] div_reg;
    reg  [6:0]  cnt_reg;
    reg         arm_reg;
    reg         lock_reg;
    reg         syl_reg;
    reg  [15:0] txw_reg;
    reg  [15:0] rsh_reg;

    // true while count c falls in the slot this port owns
    function act;
        input [6:0] c;
        input [1:0] s;
        begin
            act = (c[6:4] == {1'b0, s});
        end
    endfunction

    wire [15:0] hm1   = (half == 16'h0000) ? 16'h0000 : half - 16'h0001;
    wire        tick  = run & mst & (div_reg >= hm1);
    wire        rise  = run & (mst ? tick & ~PCM_CLK_OUT
                                   : s2_reg[0] & ~clk_s3_reg);
    wire        fall  = run & (mst ? tick & PCM_CLK_OUT
                                   : ~s2_reg[0] & clk_s3_reg);
    wire [7:0]  last  = flen - 8'h01;
    wire [6:0]  c_inc = (cnt_reg == last[6:0]) ? 7'h00
                                               : cnt_reg + 7'h01;
    wire [6:0]  cnt_n = (~mst & arm_reg) ? 7'h00 : c_inc;
    wire        lsync = ~mst & lng & s2_reg[1] & ~syl_reg;
    wire [6:0]  cnt_s = lsync ? 7'h00 : cnt_reg;
    wire [15:0] txsrc = (cnt_n[3:0] == 4'h0) ? ptx_reg : txw_reg;
    wire        take  = rise & ~burst & act(cnt_n, slot)
                        & (cnt_n[3:0] == 4'h0);
    wire        rx_ok = fall & act(cnt_s, slot) & (mst | lock_reg | lsync);
    wire        rx_done = rx_ok & (cnt_s[3:0] == 4'hF);
    wire [15:0] rx_word = {rsh_reg[14:0], s2_reg[2]};

    always @(posedge CLK_IN) begin
        if (!RST_N_IN || !run) begin
            s1_reg          <= 3'h0;
            s2_reg          <= 3'h0;
            clk_s3_reg      <= 1'b0;
            div_reg         <= 16'h0000;
            cnt_reg         <= 7'h00;
            arm_reg         <= 1'b0;
            lock_reg        <= 1'b0;
            syl_reg         <= 1'b0;
            txw_reg         <= 16'h0000;
            rsh_reg         <= 16'h0000;
            PCM_CLK_OUT     <= 1'b0;
            PCM_CLK_OE_OUT  <= 1'b0;
            PCM_SYNC_OUT    <= 1'b0;
            PCM_SYNC_OE_OUT <= 1'b0;
            PCM_DOUT_OUT    <= 1'b0;
            PCM_DOUT_OE_OUT <= 1'b0;
        end else begin
            s1_reg          <= {PCM_DIN_IN, PCM_SYNC_IN, PCM_CLK_IN};
            s2_reg          <= s1_reg;
            clk_s3_reg      <= s2_reg[0];
            PCM_CLK_OE_OUT  <= mst;
            PCM_SYNC_OE_OUT <= mst;
            div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
            if (tick)
                PCM_CLK_OUT <= ~PCM_CLK_OUT;
            if (rise) begin
                cnt_reg <= cnt_n;
                arm_reg <= 1'b0;
                txw_reg <= txsrc;
                PCM_DOUT_OUT <= txsrc[~cnt_n[3:0]];
                // released outside the owned slot and in burst
                PCM_DOUT_OE_OUT <= act(cnt_n, slot) & ~burst
                                   & (mst | lock_reg);
                if (lng)
                    PCM_SYNC_OUT <= (cnt_n < `PAP_LSYNC_BITS);
                else
                    PCM_SYNC_OUT <= (cnt_n == last[6:0]);
            end
            if (fall) begin
                syl_reg <= s2_reg[1];
                cnt_reg <= cnt_s;
                if (~mst & ~lng & s2_reg[1]) begin
                    arm_reg  <= 1'b1;
                    lock_reg <= 1'b1;
                end
                if (lsync)
                    lock_reg <= 1'b1;
                if (rx_ok)
                    rsh_reg <= rx_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone classic slave, one wait state
    wire        req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
    wire        wr  = req & WB_WE_IN;
    wire        rd  = req & ~WB_WE_IN;
    wire [31:0] nc  = merge(ctrl_reg, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] keep =
        ((ctrl_reg[`PAP_PCM_EN] &
          |((nc ^ ctrl_reg) & `PAP_LOCK_PCM)) ? `PAP_LOCK_PCM : 32'h0) |
        ((ctrl_reg[`PAP_I0_EN] &
          |((nc ^ ctrl_reg) & `PAP_LOCK_I0)) ? `PAP_LOCK_I0 : 32'h0) |
        ((ctrl_reg[`PAP_I1_EN] &
          |((nc ^ ctrl_reg) & `PAP_LOCK_I1)) ? `PAP_LOCK_I1 : 32'h0);
    wire        wctl = wr & (WB_ADR_IN == `PAP_REG_CTRL);
    wire [31:0] wst  = merge(32'h0, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] npd  = merge({16'h0000, pdiv_reg}, WB_DAT_IN, WB_SEL_IN);
    wire [5:0]  w1c  = (wr & (WB_ADR_IN == `PAP_REG_STAT))
                       ? wst[5:0] & `PAP_ST_W1C : 6'h00;
    wire [5:0]  rclr = {1'b0,
                        rd & (WB_ADR_IN == `PAP_REG_I1RX),
                        rd & (WB_ADR_IN == `PAP_REG_I0RX),
                        2'h0,
                        rd & (WB_ADR_IN == `PAP_REG_PRX)};
    wire [5:0]  sets = {muxbad & ctrl_reg[`PAP_PCM_EN],
                        i1_pair,
                        i0_pair,
                        wctl & (keep != 32'h0),
                        take & ~fresh_reg,
                        rx_done};

    always @* begin
        case (WB_ADR_IN)
            `PAP_REG_CTRL: rdat = ctrl_reg;
            `PAP_REG_PDIV: rdat = {16'h0000, pdiv_reg};
            `PAP_REG_PTX:  rdat = {16'h0000, ptx_reg};
            `PAP_REG_PRX:  rdat = {16'h0000, prx_reg};
            `PAP_REG_STAT: rdat = {26'h0, stat_reg};
            `PAP_REG_I0TX: rdat = i0tx_reg;
            `PAP_REG_I0RX: rdat = {i0_rxr, i0_rxl};
            `PAP_REG_I1TX: rdat = i1tx_reg;
            `PAP_REG_I1RX: rdat = {i1_rxr, i1_rxl};
            default:       rdat = 32'h00000000;
        endcase
    end

    always @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h00000000;
            ctrl_reg   <= `PAP_CTRL_RST;
            pdiv_reg   <= `PAP_PCM_DIV_RST;
            ptx_reg    <= 16'h0000;
            fresh_reg  <= 1'b0;
            prx_reg    <= 16'h0000;
            stat_reg   <= 6'h00;
            i0tx_reg   <= 32'h00000000;
            i1tx_reg   <= 32'h00000000;
        end else begin
            WB_ACK_OUT <= req;
            if (rd)
                WB_DAT_OUT <= rdat;
            // a set in the same cycle as its clear wins
            stat_reg <= (stat_reg & ~(w1c | rclr)) | sets;
            if (rx_done)
                prx_reg <= rx_word;
            if (take)
                fresh_reg <= 1'b0;
            if (wr) begin
                case (WB_ADR_IN)
                    // mode and burst entry only by host write
                    `PAP_REG_CTRL:
                        ctrl_reg <= (nc & ~keep) | (ctrl_reg & keep);
                    `PAP_REG_PDIV:
                        pdiv_reg <= npd[15:0];
                    `PAP_REG_PTX: begin
                        ptx_reg   <= wst[15:0] | (ptx_reg
                                     & ~{{8{WB_SEL_IN[1]}},
                                         {8{WB_SEL_IN[0]}}});
                        fresh_reg <= 1'b1;
                    end
                    `PAP_REG_I0TX:
                        i0tx_reg <= merge(i0tx_reg, WB_DAT_IN, WB_SEL_IN);
                    `PAP_REG_I1TX:
                        i1tx_reg <= merge(i1tx_reg, WB_DAT_IN, WB_SEL_IN);
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // two independent i2s ports
    pap_i2s u_i2s0 (
        .clk_in       (CLK_IN),
        .rst_n_in     (RST_N_IN),
        .en_in        (ctrl_reg[`PAP_I0_EN]),
        .master_in    (ctrl_reg[`PAP_I0_EN + 1]),
        .wide_in      (ctrl_reg[`PAP_I0_EN + 2]),
        .tx_left_in   (i0tx_reg[15:0]),
        .tx_right_in  (i0tx_reg[31:16]),
        .sck_in       (I2S0_SCK_IN),
        .ws_in        (I2S0_WS_IN),
        .sdi_in       (I2S0_SDI_IN),
        .sck_out      (I2S0_SCK_OUT),
        .sck_oe_out   (I2S0_SCK_OE_OUT),
        .ws_out       (I2S0_WS_OUT),
        .ws_oe_out    (I2S0_WS_OE_OUT),
        .sdo_out      (I2S0_SDO_OUT),
        .sdo_oe_out   (I2S0_SDO_OE_OUT),
        .rx_left_out  (i0_rxl),
        .rx_right_out (i0_rxr),
        .pair_out     (i0_pair)
    );

    pap_i2s u_i2s1 (
        .clk_in       (CLK_IN),
        .rst_n_in     (RST_N_IN),
        .en_in        (ctrl_reg[`PAP_I1_EN]),
        .master_in    (ctrl_reg[`PAP_I1_EN + 1]),
        .wide_in      (ctrl_reg[`PAP_I1_EN + 2]),
        .tx_left_in   (i1tx_reg[15:0]),
        .tx_right_in  (i1tx_reg[31:16]),
        .sck_in       (I2S1_SCK_IN),
        .ws_in        (I2S1_WS_IN),
        .sdi_in       (I2S1_SDI_IN),
        .sck_out      (I2S1_SCK_OUT),
        .sck_oe_out   (I2S1_SCK_OE_OUT),
        .ws_out       (I2S1_WS_OUT),
        .ws_oe_out    (I2S1_WS_OE_OUT),
        .sdo_out      (I2S1_SDO_OUT),
        .sdo_oe_out   (I2S1_SDO_OE_OUT),
        .rx_left_out  (i1_rxl),
        .rx_right_out (i1_rxr),
        .pair_out     (i1_pair)
    );

    // slave bit clocks are sampled at 25 MHz: external i2s clock must
    // stay at or below 3.072 MHz, pcm slave / burst clock well below
    // the system clock

endmodule

// ### bench/pap_chk.sv
// pin and register handshake assertions for the audio port top
// assumes binding into pap_top; one clock domain, CLK_IN
module pap_chk (
    input logic CLK_IN, RST_N_IN, WB_CYC_IN, WB_STB_IN, WB_ACK_OUT,
    input logic PCM_CLK_OE_OUT, PCM_SYNC_OE_OUT, PCM_DOUT_OE_OUT,
    input logic I2S0_SCK_OUT, I2S0_SCK_OE_OUT, I2S0_WS_OUT,
    input logic I2S0_WS_OE_OUT, I2S0_SDO_OUT, I2S0_SDO_OE_OUT,
    input logic I2S1_SCK_OE_OUT, I2S1_WS_OE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    property p_ack;
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_rst;
        $rose(RST_N_IN) |-> !(I2S0_SDO_OE_OUT | I2S0_SCK_OE_OUT
            | PCM_CLK_OE_OUT | PCM_DOUT_OE_OUT);
    endproperty
    a_rst: assert property (p_rst) else $error("pin driven at reset");
    property p_mst;
        I2S0_SCK_OE_OUT |-> I2S0_WS_OE_OUT && I2S0_SDO_OE_OUT;
    endproperty
    a_mst: assert property (p_mst) else $error("master pins off");
    property p_slv;
        !I2S1_SCK_OE_OUT |-> !I2S1_WS_OE_OUT;
    endproperty
    a_slv: assert property (p_slv) else $error("slave drives ws");
    property p_dat;
        I2S0_SDO_OE_OUT && $changed(I2S0_SDO_OUT) |-> !I2S0_SCK_OUT;
    endproperty
    a_dat: assert property (p_dat) else $error("data moved sck high");
    property p_ws;
        I2S0_WS_OE_OUT && $changed(I2S0_WS_OUT) |-> !I2S0_SCK_OUT;
    endproperty
    a_ws: assert property (p_ws) else $error("ws moved sck high");
    property p_sck;
        disable iff (!RST_N_IN || !I2S0_SCK_OE_OUT)
        $rose(I2S0_SCK_OUT) |-> I2S0_SCK_OUT[*5] ##[1:5] !I2S0_SCK_OUT;
    endproperty
    a_sck: assert property (p_sck) else $error("sck high time");
    property p_pcm;
        PCM_CLK_OE_OUT |-> PCM_SYNC_OE_OUT;
    endproperty
    a_pcm: assert property (p_pcm) else $error("sync not driven");
    c_ws: cover property ($changed(I2S0_WS_OUT) && I2S0_WS_OE_OUT);
    c_pcm: cover property ($rose(PCM_CLK_OE_OUT));
    c_ack: cover property (WB_ACK_OUT);
endmodule
bind pap_top pap_chk pap_chk_inst (.*);

// ### bench/pap_codec.sv
// codec model: listens to port 0, clocks port 1 as i2s master
// assumes port 0 is master and port 1 slave; bench clock drives it
module pap_codec (
    input  logic        CLK_IN, run, wide, I2S0_SCK_OUT, I2S0_WS_OUT,
    input  logic        I2S0_SDO_OUT,
    input  logic [15:0] tl, tr,
    output logic        I2S1_SCK_IN, I2S1_WS_IN, I2S1_SDI_IN,
    output logic [15:0] rl, rr,
    output logic [8:0]  pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0]  b = 0, c = 0;
    logic [31:0] sr;
    logic        pws;
    wire  [4:0]  nb = b + 5'h01;
    wire  [15:0] w = nb[4] ? tr : tl;
    wire  [15:0] pw = nb[4] ? tl : tr;
    wire  [31:0] n = {sr[30:0], I2S0_SDO_OUT};
    always @(posedge I2S0_SCK_OUT) begin
        sr <= n;
        pws <= I2S0_WS_OUT;
        if (I2S0_WS_OUT != pws) begin
            if (pws) rr <= wide ? n[24:9] : n[15:0];
            else rl <= wide ? n[24:9] : n[15:0];
            if (wide) pad <= n[8:0];
        end
    end
    // half period 10 clocks, 1.25 MHz bit clock
    always @(posedge CLK_IN) begin
        if (!run) begin
            I2S1_SCK_IN <= 0;
            c <= 0;
            b <= nb;
            I2S1_WS_IN <= b[4];
            I2S1_SDI_IN <= b[0];
        end else if (c == 5'h09) begin
            c <= 0;
            I2S1_SCK_IN <= ~I2S1_SCK_IN;
            if (I2S1_SCK_IN) begin
                b <= nb;
                I2S1_WS_IN <= nb[4];
                I2S1_SDI_IN <= nb[3:0] == 0 ? pw[0] : w[5'h10 - nb[3:0]];
            end
        end else c <= c + 5'h01;
    end
endmodule

// ### bench/pap_top_tb.sv
// register level bench for the audio port, codec model on the pins
// assumes pap_top, pap_codec and pap_chk compiled before it
module pap_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_IN = 0, RST_N_IN = 0, WB_CYC_IN = 0, WB_WE_IN = 0, run = 0;
    logic [7:0] WB_ADR_IN = 0;
    logic [31:0] WB_DAT_IN = 0, WB_DAT_OUT, q;
    logic [15:0] tl = 16'hA5C3, tr = 16'h3C5A, rl, rr;
    logic [8:0] pad;
    logic wide = 0, WB_ACK_OUT, PCM_CLK_OUT, PCM_CLK_OE_OUT, PCM_SYNC_OUT;
    logic PCM_SYNC_OE_OUT, PCM_DOUT_OUT, PCM_DOUT_OE_OUT, I2S0_SCK_OUT;
    logic I2S0_SCK_OE_OUT, I2S0_WS_OUT, I2S0_WS_OE_OUT, I2S0_SDO_OUT;
    logic I2S0_SDO_OE_OUT, I2S1_SCK_OUT, I2S1_SCK_OE_OUT, I2S1_WS_OUT;
    logic I2S1_WS_OE_OUT, I2S1_SDO_OUT, I2S1_SDO_OE_OUT, I2S1_SCK_IN;
    logic I2S1_WS_IN, I2S1_SDI_IN;
    int error_cnt = 0, cmp_count = 0;
    time t;
    wire WB_STB_IN = WB_CYC_IN;
    wire [3:0] WB_SEL_IN = 4'hF;
    // loopbacks, released lines pulled low
    wire PCM_CLK_IN = PCM_CLK_OE_OUT & PCM_CLK_OUT;
    wire PCM_SYNC_IN = PCM_SYNC_OE_OUT & PCM_SYNC_OUT;
    wire PCM_DIN_IN = PCM_DOUT_OE_OUT & PCM_DOUT_OUT;
    wire I2S0_SCK_IN = I2S0_SCK_OE_OUT & I2S0_SCK_OUT;
    wire I2S0_WS_IN = I2S0_WS_OE_OUT & I2S0_WS_OUT;
    wire I2S0_SDI_IN = I2S0_SDO_OE_OUT & I2S0_SDO_OUT;
    pap_top pap_top_inst (.*);
    pap_codec pap_codec_inst (.*);
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_IN);
        WB_CYC_IN <= 1;
        WB_WE_IN <= w;
        WB_ADR_IN <= a;
        WB_DAT_IN <= d;
        do @(posedge CLK_IN); while (WB_ACK_OUT !== 1'b1);
        q = WB_DAT_OUT;
        WB_CYC_IN <= 0;
    endtask
    task pcm_per(input int e);
        @(posedge PCM_CLK_OUT);
        t = $time;
        @(posedge PCM_CLK_OUT);
        chk(32'(($time - t) / 40), e);
    endtask
    task close_out;
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial forever #20 CLK_IN = ~CLK_IN;
    initial begin
        repeat (20000) @(posedge CLK_IN);
        error_cnt++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge CLK_IN);
        RST_N_IN <= 1;
        chk({I2S0_SDO_OE_OUT, I2S1_SDO_OE_OUT, PCM_DOUT_OE_OUT}, 0);
        wb(0, 8'h00, 0);
        chk(q, 0);
        wb(0, 8'h04, 0);
        chk(q, 32'h000000C3);
        wb(0, 8'hFC, 0);
        chk(q, 0);
        wb(1, 8'h14, 32'h1234ABCD);
        wb(1, 8'h00, 32'h00030000);
        repeat (1600) @(posedge CLK_IN);
        chk({rr, rl}, 32'h1234ABCD);
        wb(0, 8'h18, 0);
        chk(q, 32'h1234ABCD);
        @(posedge I2S0_WS_OUT);
        t = $time;
        @(posedge I2S0_WS_OUT);
        chk(32'(($time - t) / 80), 260);
        wb(1, 8'h00, 32'h00070000);
        wb(0, 8'h00, 0);
        chk(q, 32'h00030000);
        wb(0, 8'h10, 0);
        chk(q & 4, 4);
        wb(1, 8'h10, 4);
        wb(0, 8'h10, 0);
        chk(q & 4, 0);
        wb(1, 8'h00, 0);
        wide <= 1;
        run <= 1;
        wb(1, 8'h14, 32'h6E2D91F0);
        wb(1, 8'h00, 32'h00170000);
        repeat (2600) @(posedge CLK_IN);
        chk({23'h0, pad}, 0);
        chk({rr, rl}, 32'h6E2D91F0);
        wb(0, 8'h20, 0);
        chk(q, {tr, tl});
        chk({I2S1_SCK_OE_OUT, I2S1_SDO_OE_OUT}, 1);
        wb(1, 8'h00, 32'h00000003);
        pcm_per(390);
        wb(1, 8'h00, 0);
        wb(1, 8'h08, 32'h00005AA5);
        wb(1, 8'h00, 32'h00000007);
        pcm_per(96);
        repeat (3400) @(posedge CLK_IN);
        wb(0, 8'h0C, 0);
        chk(q, 32'h00005AA5);
        wb(0, 8'h10, 0);
        chk(q & 2, 2);
        wb(1, 8'h00, 0);
        wb(1, 8'h00, 32'h00000009);
        wb(0, 8'h10, 0);
        chk(q & 32'h20, 32'h20);
        wb(1, 8'h00, 0);
        wb(1, 8'h00, 32'h0000002B);
        pcm_per(194);
        wb(1, 8'h00, 0);
        wb(1, 8'h00, 32'h0000000D);
        repeat (400) @(posedge CLK_IN);
        chk({PCM_CLK_OE_OUT, PCM_DOUT_OE_OUT}, 0);
        close_out;
    end
endmodule
